/* hdl/vco_pkg.sv */
/*
  Shared constants for the video clock output stage: register map, field
  positions, reset values, division encodings and default rate periods.
  Assumes a single 250 MHz system clock drives every consumer.
*/
package vco_pkg;

  // Register byte offsets
  localparam logic [7:0] VCO_OFS_CTRL = 8'h00;
  localparam logic [7:0] VCO_OFS_RATE = 8'h04;
  localparam logic [7:0] VCO_OFS_STAT = 8'h08;
  localparam int VCO_ADDR_W = 8;

  // Control register fields
  localparam int VCO_CTRL_NONSTD = 0;
  localparam int VCO_CTRL_DIV_DIFF = 2;
  localparam int VCO_CTRL_DIV_A = 4;
  localparam int VCO_CTRL_DIV_B = 6;
  localparam int VCO_CTRL_DRV_A = 8;
  localparam int VCO_CTRL_DRV_B = 9;
  localparam logic [31:0] VCO_CTRL_MASK = 32'h0000_03fd;
  localparam logic [31:0] VCO_CTRL_RST = 32'h0000_0000;

  // Non-standard rate register: half period in system clocks
  localparam int VCO_HALF_W = 16;
  localparam logic [15:0] VCO_RATE_RST = 16'h0004;

  // Status register fields
  localparam int VCO_STAT_STDBY = 8;
  localparam int VCO_STAT_OUT_A = 9;
  localparam int VCO_STAT_OUT_B = 10;
  localparam int VCO_STAT_OUT_D = 11;
  localparam int VCO_STAT_SRC = 12;

  // Division ratio encodings; code 3 behaves as divide by one
  typedef enum logic [1:0] {VCO_DIV1, VCO_DIV2, VCO_DIV4, VCO_DIV_RSV} vco_div_e;

  // Standby code of the select pins
  localparam logic [5:0] VCO_STD_STANDBY = 6'h00;

  // Half periods of the four pin-selected fundamental rates
  localparam logic [15:0] VCO_HALF_STD0 = 16'h0001;
  localparam logic [15:0] VCO_HALF_STD1 = 16'h0002;
  localparam logic [15:0] VCO_HALF_STD2 = 16'h0003;
  localparam logic [15:0] VCO_HALF_STD3 = 16'h0004;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int VCO_HTRANS_ACT = 1;

endpackage

/* hdl/vco_rate_gen.sv */
/*
  Fundamental rate generator: emits a one-cycle tick at every half period
  of the fundamental video clock.
  Assumes the half period is given in system clock cycles.
*/
`timescale 1ns/1ps
module vco_rate_gen
  import vco_pkg::*;
#(
  parameter int HALF_W = VCO_HALF_W
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Rate
  input wire logic [HALF_W-1:0] half_period,
  output logic tick
);

  logic [HALF_W-1:0] cnt_r;
  logic [HALF_W-1:0] cnt_nxt;
  logic [HALF_W-1:0] last;

  // A zero period would stall the clock, so it runs as one
  always_comb
  begin
    last = (half_period == '0) ? '0 : half_period - HALF_W'(1);
    tick = (cnt_r >= last);
    cnt_nxt = tick ? '0 : cnt_r + HALF_W'(1);
  end

  // Counter register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule

/* hdl/vco_divider.sv */
/*
  Per-output divider: toggles its clock every 1, 2 or 4 fundamental ticks.
  Assumes ticks come from the rate generator; park forces the output low.
*/
`timescale 1ns/1ps
module vco_divider
  import vco_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic tick,
  input wire logic park,
  input wire logic [1:0] ratio_sel,
  // Outputs
  output logic clk_out,
  output logic clk_out_n,
  output logic [1:0] ratio_q
);

  logic out_r, out_nxt;
  logic outn_r, outn_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [1:0] ratio_r, ratio_nxt;
  logic [1:0] limit;

  // Ticks per half cycle, minus one
  always_comb
  begin
    case (vco_div_e'(ratio_r))
      VCO_DIV2: limit = 2'd1;
      VCO_DIV4: limit = 2'd3;
      default: limit = 2'd0;
    endcase
  end

  // New ratio is loaded as a full cycle ends or while parked, so no short pulse appears
  always_comb
  begin
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    ratio_nxt = ratio_r;
    if (park)
    begin
      out_nxt = 1'b0;
      cnt_nxt = 2'd0;
      ratio_nxt = ratio_sel; // RULE8
    end
    else if (tick)
    begin
      if (cnt_r >= limit)
      begin
        out_nxt = ~out_r; // RULE3
        cnt_nxt = 2'd0;
        if (out_r)
          ratio_nxt = ratio_sel; // RULE8
      end
      else
        cnt_nxt = cnt_r + 2'd1;
    end
    outn_nxt = ~out_nxt;
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      out_r <= 1'b0;
      outn_r <= 1'b1;
      cnt_r <= 2'd0;
      ratio_r <= 2'd0;
    end
    else
    begin
      out_r <= out_nxt;
      outn_r <= outn_nxt;
      cnt_r <= cnt_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  assign clk_out = out_r;
  assign clk_out_n = outn_r;
  assign ratio_q = ratio_r;

endmodule

/* hdl/vco_top.sv */
/*
  Video clock output stage: AHB-Lite register slave, fundamental rate
  selection from pins or software, three divided clock outputs, standby.
  Assumes select pins and bus signals are synchronous to hclk.
*/
// Function
// RULE1: After reset every output runs at the rate chosen by the select pins.
// RULE2: Software may replace the pin-chosen rate with a programmed rate.
// RULE3: Each output may run at the fundamental rate, half of it or a quarter.
// RULE4: Each output keeps its own division setting.
// RULE5: Select code zero puts the differential pair in high impedance.
// RULE6: Select code zero holds both single-ended outputs low.
// RULE7: Each single-ended output has a drive strength bit, low after reset.
// RULE8: A new division ratio takes effect only at a clock-cycle boundary.
`timescale 1ns/1ps
module vco_top
  import vco_pkg::*;
(
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Video standard select pins
  input wire logic [5:0] video_standard_select,
  // Single-ended clocks and drive strength
  output logic video_clock_out_a,
  output logic video_clock_out_b,
  output logic drive_high_a,
  output logic drive_high_b,
  // Differential clock pair
  output logic video_clock_out_diff_p,
  output logic video_clock_out_diff_n,
  output logic video_clock_out_diff_oe
);

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [VCO_HALF_W-1:0] rate_r, rate_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [VCO_ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
  logic oe_r, oe_nxt;
  logic hreadyout_r;
  logic hresp_r;
  logic addr_ok;
  logic standby;
  logic [VCO_HALF_W-1:0] half_std;
  logic [VCO_HALF_W-1:0] half_sel;
  logic tick;
  logic [1:0] ratio_d, ratio_a, ratio_b;
  logic diff_p, diff_n, out_a, out_b;
  logic [31:0] status;

  // Standby and fundamental rate choice
  always_comb
  begin
    standby = (video_standard_select == VCO_STD_STANDBY);
    case (video_standard_select[1:0])
      2'd0: half_std = VCO_HALF_STD0;
      2'd1: half_std = VCO_HALF_STD1;
      2'd2: half_std = VCO_HALF_STD2;
      default: half_std = VCO_HALF_STD3;
    endcase
    if (ctrl_r[VCO_CTRL_NONSTD])
      half_sel = rate_r; // RULE2
    else
      half_sel = half_std; // RULE1
  end

  // One fundamental generator shared by all outputs
  vco_rate_gen #(
    .HALF_W(VCO_HALF_W)
  ) u_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .half_period(half_sel),
    .tick(tick)
  );

  // Independent dividers, one per output
  vco_divider u_div_diff (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .park(standby),
    .ratio_sel(ctrl_r[VCO_CTRL_DIV_DIFF +: 2]), // RULE4
    .clk_out(diff_p),
    .clk_out_n(diff_n),
    .ratio_q(ratio_d)
  );

  vco_divider u_div_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .park(standby), // RULE6
    .ratio_sel(ctrl_r[VCO_CTRL_DIV_A +: 2]), // RULE4
    .clk_out(out_a),
    .clk_out_n(),
    .ratio_q(ratio_a)
  );

  vco_divider u_div_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .park(standby), // RULE6
    .ratio_sel(ctrl_r[VCO_CTRL_DIV_B +: 2]), // RULE4
    .clk_out(out_b),
    .clk_out_n(),
    .ratio_q(ratio_b)
  );

  // Status word shows live pins, standby and output levels
  always_comb
  begin
    status = 32'h0000_0000;
    status[5:0] = video_standard_select;
    status[VCO_STAT_STDBY] = standby;
    status[VCO_STAT_OUT_A] = out_a;
    status[VCO_STAT_OUT_B] = out_b;
    status[VCO_STAT_OUT_D] = diff_p;
    status[VCO_STAT_SRC] = ctrl_r[VCO_CTRL_NONSTD];
  end

  // Bus slave: zero wait states, read data loaded in the address phase
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    rate_nxt = rate_r;
    hrdata_nxt = hrdata_r;
    wr_pend_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    addr_ok = hsel && htrans[VCO_HTRANS_ACT] && hready;
    // Write data arrives one cycle after its address
    if (wr_pend_r)
    begin
      if (wr_addr_r == VCO_OFS_CTRL)
        ctrl_nxt = hwdata & VCO_CTRL_MASK; // RULE7
      else if (wr_addr_r == VCO_OFS_RATE)
        rate_nxt = hwdata[VCO_HALF_W-1:0]; // RULE2
    end
    if (addr_ok)
    begin
      wr_pend_nxt = hwrite;
      wr_addr_nxt = haddr[VCO_ADDR_W-1:0];
      if (!hwrite)
      begin
        if (haddr[VCO_ADDR_W-1:0] == VCO_OFS_CTRL)
          hrdata_nxt = ctrl_r;
        else if (haddr[VCO_ADDR_W-1:0] == VCO_OFS_RATE)
          hrdata_nxt = {16'h0000, rate_r};
        else if (haddr[VCO_ADDR_W-1:0] == VCO_OFS_STAT)
          hrdata_nxt = status;
        else
          hrdata_nxt = 32'h0000_0000; // Unmapped reads zero
      end
    end
    oe_nxt = !standby; // RULE5
  end

  // Registers of the bus slave and pad control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= VCO_CTRL_RST; // RULE1
      rate_r <= VCO_RATE_RST;
      hrdata_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      oe_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      rate_r <= rate_nxt;
      hrdata_r <= hrdata_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      oe_r <= oe_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0; // No error response exists
    end
  end

  // Outputs all come from flops; hsize ignored as only words are used
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign video_clock_out_a = out_a;
  assign video_clock_out_b = out_b;
  assign drive_high_a = ctrl_r[VCO_CTRL_DRV_A]; // RULE7
  assign drive_high_b = ctrl_r[VCO_CTRL_DRV_B]; // RULE7
  assign video_clock_out_diff_p = diff_p;
  assign video_clock_out_diff_n = diff_n;
  assign video_clock_out_diff_oe = oe_r; // RULE5

  // Checks
  property p_pin_rate;
    @(posedge hclk) disable iff (!hresetn)
      !ctrl_r[VCO_CTRL_NONSTD] && !(wr_pend_r && wr_addr_r == VCO_OFS_CTRL)
      |=> !ctrl_r[VCO_CTRL_NONSTD];
  endproperty
  a_pin_rate: assert property (p_pin_rate) else $error("rate source left pins"); // RULE1

  // Code 1 runs at a half period of two cycles: tick, gap, tick
  property p_rule1;
    @(posedge hclk) disable iff (!hresetn)
      tick && !ctrl_r[VCO_CTRL_NONSTD] && video_standard_select[1:0] == 2'd1
      ##1 !ctrl_r[VCO_CTRL_NONSTD] && video_standard_select[1:0] == 2'd1
      |-> !tick ##1 (tick || ctrl_r[VCO_CTRL_NONSTD]
                     || video_standard_select[1:0] != 2'd1);
  endproperty
  a_rule1: assert property (p_rule1) else $error("pin rate not used"); // RULE1

  property p_rule2;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend_r && wr_addr_r == VCO_OFS_CTRL && hwdata[VCO_CTRL_NONSTD]
      |=> ctrl_r[VCO_CTRL_NONSTD] && u_rate.half_period == rate_r;
  endproperty
  a_rule2: assert property (p_rule2) else $error("programmed rate not used"); // RULE2

  property p_rule3;
    @(posedge hclk) disable iff (!hresetn)
      !standby && !$past(standby) && $changed(out_a) |-> $past(tick);
  endproperty
  a_rule3: assert property (p_rule3) else $error("output moved without tick"); // RULE3

  property p_rule4;
    @(posedge hclk) disable iff (!hresetn)
      $changed(ratio_a) |-> ratio_a == $past(ctrl_r[VCO_CTRL_DIV_A +: 2]);
  endproperty
  a_rule4: assert property (p_rule4) else $error("ratio a from wrong field"); // RULE4

  property p_rule4_b;
    @(posedge hclk) disable iff (!hresetn)
      $changed(ratio_b) |-> ratio_b == $past(ctrl_r[VCO_CTRL_DIV_B +: 2]);
  endproperty
  a_rule4_b: assert property (p_rule4_b) else $error("ratio b from wrong field"); // RULE4

  property p_rule4_d;
    @(posedge hclk) disable iff (!hresetn)
      $changed(ratio_d) |-> ratio_d == $past(ctrl_r[VCO_CTRL_DIV_DIFF +: 2]);
  endproperty
  a_rule4_d: assert property (p_rule4_d) else $error("ratio d from wrong field"); // RULE4

  property p_rule5;
    @(posedge hclk) disable iff (!hresetn)
      standby |=> !video_clock_out_diff_oe;
  endproperty
  a_rule5: assert property (p_rule5) else $error("diff pair driven in standby"); // RULE5

  // Pair must come back once a rate code is selected
  property p_rule5_on;
    @(posedge hclk) disable iff (!hresetn)
      !standby |=> video_clock_out_diff_oe;
  endproperty
  a_rule5_on: assert property (p_rule5_on) else $error("diff pair not driven"); // RULE5

  property p_rule6;
    @(posedge hclk) disable iff (!hresetn)
      standby [*2] |-> !video_clock_out_a && !video_clock_out_b;
  endproperty
  a_rule6: assert property (p_rule6) else $error("single outputs not low"); // RULE6

  property p_rule7;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend_r && wr_addr_r == VCO_OFS_CTRL
      |=> drive_high_a == $past(hwdata[VCO_CTRL_DRV_A])
          && drive_high_b == $past(hwdata[VCO_CTRL_DRV_B]);
  endproperty
  a_rule7: assert property (p_rule7) else $error("drive bit not stored"); // RULE7

  property p_rule8;
    @(posedge hclk) disable iff (!hresetn)
      $changed(ratio_b) |-> !video_clock_out_b
        && ($past(video_clock_out_b) || $past(standby));
  endproperty
  a_rule8: assert property (p_rule8) else $error("ratio changed mid cycle"); // RULE8

  // Same boundary rule on the differential pair
  property p_rule8_d;
    @(posedge hclk) disable iff (!hresetn)
      $changed(ratio_d) |-> !diff_p && ($past(diff_p) || $past(standby));
  endproperty
  a_rule8_d: assert property (p_rule8_d) else $error("diff ratio changed mid cycle"); // RULE8

  // Main scenarios
  c_standby: cover property (@(posedge hclk) disable iff (!hresetn) $rose(standby));
  c_nonstd: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl_r[VCO_CTRL_NONSTD] && tick);
  c_ratio: cover property (@(posedge hclk) disable iff (!hresetn)
    $changed(ratio_a) && !standby);
  c_div4: cover property (@(posedge hclk) disable iff (!hresetn)
    ratio_d == 2'd2 && $rose(diff_p));
  c_drive: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(drive_high_a));

endmodule

/* dv/vco_sink.sv */
/*
  Consumer model of one sample clock: measures cycles between level changes.
  Assumes the clock is sampled on the rising edge of hclk.
*/
`timescale 1ns/1ps
module vco_sink
(
  // System
  input wire logic hclk,
  input wire logic hresetn,
  // Observed clock and clear of the minimum
  input wire logic clk_in,
  input wire logic clr,
  // Intervals in hclk cycles
  output logic [15:0] last_iv,
  output logic [15:0] min_iv
);
  logic prev_r;
  logic [15:0] cnt_r;
  // Counter keeps running over a clear, so the next interval is whole
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= 1'b0;
      cnt_r <= 16'h0001;
      last_iv <= 16'h0000;
      min_iv <= 16'hffff;
    end
    else
    begin
      prev_r <= clk_in;
      cnt_r <= (clk_in != prev_r) ? 16'h0001 : cnt_r + 16'h0001;
      if (clk_in != prev_r)
        last_iv <= cnt_r;
      // Shortest pulse seen since clear
      if (clr)
        min_iv <= 16'hffff;
      else if (clk_in != prev_r && cnt_r < min_iv)
        min_iv <= cnt_r;
    end
  end
endmodule

/* dv/tb_video_clock_output_stage.sv */
/*
  Self-checking bench: AHB-Lite master, three clock consumers, random configs.
  Assumes hready is looped back from hreadyout and word-only transfers.
*/
`timescale 1ns/1ps
module tb_video_clock_output_stage;
  import vco_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
  logic [31:0] haddr, hwdata, hrdata, rd, ctrl, nctrl;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] pins, code;
  logic [15:0] rate, nrate;
  logic ca, cb, dha, dhb, dp, dn, doe;
  wire [15:0] iv [3];
  wire [15:0] mn [3];
  logic [31:0] lb [3];
  int n_fail, n_tests, i, j, k;
  int sh [3] = '{VCO_CTRL_DIV_A, VCO_CTRL_DIV_B, VCO_CTRL_DIV_DIFF};
  integer seed = 32'he643;
  assign hready = hreadyout;
  vco_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .video_standard_select(pins),
    .video_clock_out_a(ca), .video_clock_out_b(cb), .drive_high_a(dha),
    .drive_high_b(dhb), .video_clock_out_diff_p(dp), .video_clock_out_diff_n(dn),
    .video_clock_out_diff_oe(doe));
  // One consumer per output
  vco_sink s_a (.hclk(hclk), .hresetn(hresetn), .clk_in(ca), .clr(clr),
    .last_iv(iv[0]), .min_iv(mn[0]));
  vco_sink s_b (.hclk(hclk), .hresetn(hresetn), .clk_in(cb), .clr(clr),
    .last_iv(iv[1]), .min_iv(mn[1]));
  vco_sink s_d (.hclk(hclk), .hresetn(hresetn), .clk_in(dp), .clr(clr),
    .last_iv(iv[2]), .min_iv(mn[2]));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0000_00, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Toggle spacing: half period times ratio, code 3 as divide by one
  function automatic logic [31:0] iv_exp(logic [5:0] c, logic [15:0] r, logic [31:0] ct,
    int s);
    logic [31:0] h;
    h = ct[0] ? {16'h0000, r} : c[1:0] + 1;
    return ct[s+:2] == 2'd1 ? h * 2 : ct[s+:2] == 2'd2 ? h * 4 : h;
  endfunction

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // Watchdog well past the expected run of a few thousand cycles
  initial
  begin
    #200000;
    n_fail++;
    end_of_test;
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    pins = 6'h02;
    clr = 1'b0;
    ctrl = VCO_CTRL_RST;
    rate = VCO_RATE_RST;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({dhb, dha}, 32'h0000_0000);
    bus(1'b0, VCO_OFS_CTRL, 32'h0000_0000);
    chk(rd, VCO_CTRL_RST);
    chk(hresp, 1'b0);
    bus(1'b0, 8'h0c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    repeat (150) @(posedge hclk);
    for (k = 0; k < 3; k++)
      chk(iv[k], iv_exp(pins, rate, ctrl, sh[k]));
    // Random configurations with forced distinct ratios and software rate
    for (i = 0; i < 10; i++)
    begin
      code = $random(seed);
      if (code == 6'h00)
        code = 6'h01;
      nctrl = $random(seed) & VCO_CTRL_MASK;
      nrate = ($random(seed) & 7) + 1;
      if (i == 0)
        nctrl = 32'h0000_0018;
      if (i == 1)
        nctrl = nctrl | 32'h0000_0001;
      // Shortest legal pulse mixes the old and new half period and ratio
      for (k = 0; k < 3; k++)
      begin
        lb[k] = iv_exp(pins, rate, ctrl & 1, sh[k]) < iv_exp(code, nrate, nctrl & 1, sh[k])
          ? iv_exp(pins, rate, ctrl & 1, sh[k]) : iv_exp(code, nrate, nctrl & 1, sh[k]);
        // Programmed rate and old pin rate may each rule for a cycle or two
        if (ctrl[0] && nrate < lb[k])
          lb[k] = nrate;
        if (!nctrl[0] && pins[1:0] + 1 < lb[k])
          lb[k] = pins[1:0] + 1;
        j = iv_exp(6'h00, 16'h0001, ctrl | 1, sh[k]);
        if (iv_exp(6'h00, 16'h0001, nctrl | 1, sh[k]) < j)
          j = iv_exp(6'h00, 16'h0001, nctrl | 1, sh[k]);
        lb[k] = lb[k] * j;
      end
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      bus(1'b1, VCO_OFS_RATE, {16'h0000, nrate});
      bus(1'b1, VCO_OFS_CTRL, nctrl);
      pins <= code;
      ctrl = nctrl;
      rate = nrate;
      @(posedge hclk);
      chk({dhb, dha}, ctrl[9:8]);
      bus(1'b0, VCO_OFS_CTRL, 32'h0000_0000);
      chk(rd, ctrl);
      bus(1'b0, VCO_OFS_RATE, 32'h0000_0000);
      chk(rd, {16'h0000, rate});
      repeat (150) @(posedge hclk);
      for (k = 0; k < 3; k++)
      begin
        chk(iv[k], iv_exp(pins, rate, ctrl, sh[k]));
        chk(mn[k] >= lb[k], 1);
      end
    end
    // Standby code parks every output
    pins <= VCO_STD_STANDBY;
    repeat (3) @(posedge hclk);
    for (j = 0; j < 40; j++)
    begin
      @(posedge hclk);
      chk(doe, 1'b0);
      chk({ca, cb}, 2'b00);
    end
    bus(1'b0, VCO_OFS_STAT, 32'h0000_0000);
    chk(rd[VCO_STAT_STDBY], 1'b1);
    // Back to pin rate with no division before leaving standby
    bus(1'b1, VCO_OFS_CTRL, 32'h0000_0000);
    ctrl = VCO_CTRL_RST;
    pins <= 6'h01;
    repeat (20) @(posedge hclk);
    chk({doe, dn}, {1'b1, ~dp});
    chk({dhb, dha}, 32'h0000_0000);
    for (k = 0; k < 3; k++)
      chk(iv[k], iv_exp(pins, rate, ctrl, sh[k]));
    end_of_test;
  end
endmodule
